// ### hdl/wch_pkg.sv
// Purpose: Shared constants and register map for the four-channel window comparator.
// Assumes: Percent values are signed fixed point with 0.01 % per count (10000 = 100.00 %).
// Notes:   Register offsets are byte addresses of 32-bit words.
`default_nettype none
package wch_pkg;
  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned VAL_W          = 16;
  localparam int unsigned DEST_W         = 10;
  localparam int unsigned ADDR_W         = 8;

  // Full scale is 100.00 %, so 10.00 % hysteresis is 1000 counts.
  localparam logic [VAL_W-1:0]  HYST_MAX        = 16'h03E8;
  localparam logic [DEST_W-1:0] DEST_DISCONNECT = 10'h190;
  localparam logic [DEST_W-1:0] DEST_RESET      = 10'h190;

  // Per-channel block: base + CH_STRIDE * channel.
  localparam logic [ADDR_W-1:0] CH_STRIDE  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IN1    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IN2    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DEST   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h40;

  // Control word fields.
  localparam int unsigned CTRL_HYST_LSB = 0;
  localparam int unsigned CTRL_WIN_BIT  = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wch_pkg
`default_nettype wire

// ### hdl/wch_core_if.sv
// Purpose: Carries one channel's settings into the comparator core and its output back.
// Assumes: Single clock domain.
// Notes:   The top owns the registers; the core owns the decision state.
`default_nettype none
interface wch_core_if;
  logic signed [wch_pkg::VAL_W-1:0] in1;
  logic signed [wch_pkg::VAL_W-1:0] in2;
  logic        [wch_pkg::VAL_W-1:0] hyst;
  logic                             win_mode;
  logic                             active;
  logic                             cmp_out;
  modport top  (output in1, output in2, output hyst, output win_mode, output active,
                input cmp_out);
  modport core (input in1, input in2, input hyst, input win_mode, input active,
                output cmp_out);
endinterface : wch_core_if
`default_nettype wire

// ### hdl/wch_core.sv
// Purpose: One comparator channel with normal and window modes and hysteresis.
// Assumes: Inputs are stable registered settings; evaluated once per clock.
// Notes:   Arithmetic is widened by two bits so that differences never overflow.
`default_nettype none
module wch_core (
  input  wire logic aclk,
  input  wire logic aresetn,
  wch_core_if.core  cif
);
  localparam int unsigned W = wch_pkg::VAL_W + 2;

  logic signed [W-1:0] a;
  logic signed [W-1:0] b;
  logic signed [W-1:0] h;
  logic signed [W-1:0] mag;
  logic                next_out;

  always_comb begin
    a   = W'(cif.in1);
    b   = W'(cif.in2);
    h   = signed'({2'h0, cif.hyst});
    mag = (b < 0) ? -b : b;
    next_out = cif.cmp_out;
    if (!cif.win_mode) begin
      if (a > b + h) begin
        next_out = 1'b1;
      end else if (a <= b - h) begin
        next_out = 1'b0;
      end
    end else begin
      // Go high only when clear of both limits by more than the band, low once at least the band past a limit.
      if ((a < mag - h) && (a > h - mag)) begin
        next_out = 1'b1;
      end else if ((a >= mag + h) || (a <= -mag - h)) begin
        next_out = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cif.cmp_out <= 1'b0;
    end else if (cif.active) begin
      cif.cmp_out <= next_out;
    end
  end
endmodule : wch_core
`default_nettype wire

// ### hdl/wch_top.sv
// Purpose: Four signed comparators with window mode and hysteresis behind AXI4-Lite.
// Assumes: Values are 0.01 % per count, two's complement; one sample per aclk.
// Notes:   Outputs freeze while a channel's destination is the disconnect code.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module wch_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [wch_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [wch_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [wch_pkg::NUM_CH-1:0]       cmp_out
);
  localparam int unsigned N = wch_pkg::NUM_CH;
  localparam int unsigned V = wch_pkg::VAL_W;

  logic [V-1:0]                 in1_r  [N];
  logic [V-1:0]                 in2_r  [N];
  logic [V-1:0]                 hyst_r [N];
  logic                         win_r  [N];
  logic [wch_pkg::DEST_W-1:0]   dest_r [N];

  logic [wch_pkg::ADDR_W-1:0]   aw_addr;
  logic                         aw_held;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         w_held;
  logic                         do_write;

  // Write address and data are caught independently, in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  function automatic logic map_hit(input logic [wch_pkg::ADDR_W-1:0] adr);
    map_hit = (adr[1:0] == 2'h0) &&
              ((adr < wch_pkg::CH_STRIDE * 8'(N)) || (adr == wch_pkg::OFS_STATUS));
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= wch_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= map_hit(aw_addr) ? wch_pkg::RESP_OKAY : wch_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      localparam logic [wch_pkg::ADDR_W-1:0] BASE = 8'(g * 16);
      wch_core_if cif ();
      logic [V-1:0] hyst_wr;
      logic         sel;

      assign sel     = do_write && (aw_addr[7:4] == BASE[7:4]) && (BASE < wch_pkg::OFS_STATUS);
      // A new limit above 10.00 % is clamped so it can never reach the core.
      assign hyst_wr = (w_data[V-1:0] > wch_pkg::HYST_MAX) ? wch_pkg::HYST_MAX
                                                           : w_data[V-1:0];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          in1_r[g]  <= '0;
          in2_r[g]  <= '0;
          hyst_r[g] <= '0;
          win_r[g]  <= 1'b0;
          dest_r[g] <= wch_pkg::DEST_RESET;
        end else if (sel) begin
          unique case (aw_addr[3:0])
            wch_pkg::OFS_IN1[3:0]: begin
              if (w_strb[0]) in1_r[g][7:0]  <= w_data[7:0];
              if (w_strb[1]) in1_r[g][15:8] <= w_data[15:8];
            end
            wch_pkg::OFS_IN2[3:0]: begin
              if (w_strb[0]) in2_r[g][7:0]  <= w_data[7:0];
              if (w_strb[1]) in2_r[g][15:8] <= w_data[15:8];
            end
            wch_pkg::OFS_CTRL[3:0]: begin
              // Hysteresis is written only when both its byte strobes are set so the clamp sees both bytes.
              if (w_strb[1:0] == 2'h3) hyst_r[g] <= hyst_wr;
              if (w_strb[2]) win_r[g] <= w_data[wch_pkg::CTRL_WIN_BIT];
            end
            wch_pkg::OFS_DEST[3:0]: begin
              if (w_strb[0]) dest_r[g][7:0] <= w_data[7:0];
              if (w_strb[1]) dest_r[g][9:8] <= w_data[9:8];
            end
            default: begin
            end
          endcase
        end
      end

      assign cif.in1      = in1_r[g];
      assign cif.in2      = in2_r[g];
      assign cif.hyst     = hyst_r[g];
      assign cif.win_mode = win_r[g];
      assign cif.active   = (dest_r[g] != wch_pkg::DEST_DISCONNECT);
      assign cmp_out[g]   = cif.cmp_out;

      wch_core u_core (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cif     (cif)
      );
    end
  endgenerate

  logic [31:0] rd_word;
  logic [1:0]  rd_ch;

  always_comb begin
    rd_ch   = s_axi_araddr[5:4];
    rd_word = 32'h0;
    if (s_axi_araddr == wch_pkg::OFS_STATUS) begin
      rd_word = {28'h0, cmp_out};
    end else if (s_axi_araddr < wch_pkg::OFS_STATUS) begin
      unique case (s_axi_araddr[3:0])
        wch_pkg::OFS_IN1[3:0]:  rd_word = {{16{in1_r[rd_ch][V-1]}}, in1_r[rd_ch]};
        wch_pkg::OFS_IN2[3:0]:  rd_word = {{16{in2_r[rd_ch][V-1]}}, in2_r[rd_ch]};
        wch_pkg::OFS_CTRL[3:0]: rd_word = {15'h0, win_r[rd_ch], hyst_r[rd_ch]};
        wch_pkg::OFS_DEST[3:0]: rd_word = {22'h0, dest_r[rd_ch]};
        default:                rd_word = 32'h0;
      endcase
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= wch_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= map_hit(s_axi_araddr) ? rd_word : 32'h0;
      s_axi_rresp  <= map_hit(s_axi_araddr) ? wch_pkg::RESP_OKAY : wch_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : wch_top
`default_nettype wire

// ### sim/wch_props.sv
// Purpose: Port-level checks of the bus handshake and comparator outputs of wch_top.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound from the bench top file.
`default_nettype none
module wch_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  cmp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
  a_reset_clear: assert property ($rose(aresetn) |-> cmp_out == 4'h0)
    else $error("outputs not cleared by reset");
  // Settings only change through writes, so an output move needs a recent write.
  a_out_cause: assert property ($changed(cmp_out) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("output moved without a settings change");
endmodule // wch_props
`default_nettype wire

// ### sim/wch_top_tb_top.sv
// Purpose: Self-checking bench for wch_top driven over its register bus.
// Assumes: Byte map and one-cycle output update as handed over.
// Notes:   Write strobes stay all-ones; byte-lane behaviour is not exercised.
`default_nettype none
module wch_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] cmp_out;
  int n_mismatch = 0, n_tests = 0;
  always #10 aclk = ~aclk;
  wch_top u_wch_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_out);
  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input int d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ex);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  function automatic logic [7:0] ad(input int ch, input logic [7:0] ofs);
    return 8'(ch * 16) + ofs;
  endfunction
  // Writes input 1 of a channel step by step and checks the output after each step.
  task automatic seq(input int ch, input int v[8], input logic [7:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      wr(ad(ch, wch_pkg::OFS_IN1), v[i], wch_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("cmp_out", 32'(cmp_out[ch]), 32'(e[i]));
    end
  endtask
  task automatic cfg(input int ch, input int in2, input int ctrl);
    wr(ad(ch, wch_pkg::OFS_IN2), in2, wch_pkg::RESP_OKAY);
    wr(ad(ch, wch_pkg::OFS_CTRL), ctrl, wch_pkg::RESP_OKAY);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ad(0, wch_pkg::OFS_DEST), 32'h190, wch_pkg::RESP_OKAY);
    chk("cmp_rst", 32'(cmp_out), 32'h0);
    seq(0, '{100, 0, 0, 0, 0, 0, 0, 0}, 8'h00, 1);
    wr(ad(0, wch_pkg::OFS_DEST), 1, wch_pkg::RESP_OKAY);
    seq(0, '{100, -100, 0, 0, 0, 0, 0, 0}, 8'h01, 1);
    wr(ad(0, wch_pkg::OFS_DEST), 400, wch_pkg::RESP_OKAY);
    seq(0, '{-100, 0, 0, 0, 0, 0, 0, 0}, 8'h01, 1);
    for (int ch = 0; ch < 4; ch++) begin
      wr(ad(ch, wch_pkg::OFS_DEST), ch + 1, wch_pkg::RESP_OKAY);
      cfg(ch, 10 * ch, 0);
      seq(ch, '{10 * ch, 10 * ch + 1, 0, 0, 0, 0, 0, 0}, 8'h02, 2);
    end
    rd(wch_pkg::OFS_STATUS, 32'hF, wch_pkg::RESP_OKAY);
    seq(2, '{-5000, 0, 0, 0, 0, 0, 0, 0}, 8'h00, 1);
    rd(wch_pkg::OFS_STATUS, 32'hB, wch_pkg::RESP_OKAY);
    cfg(1, 0, 100);
    seq(1, '{-200, 100, 101, -99, -100, 0, 0, 0}, 8'h0C, 5);
    cfg(1, 0, 2000);
    seq(1, '{1001, -999, -1000, 0, 0, 0, 0, 0}, 8'h03, 3);
    cfg(3, -500, 32'h10000);
    seq(3, '{500, 499, -500, -499, 0, 0, 0, 0}, 8'h1A, 5);
    cfg(3, 500, 32'h10064);
    seq(3, '{450, 600, 450, 399, -450, -600, -399, 0}, 8'h59, 7);
    rd(ad(3, wch_pkg::OFS_IN1), 32'hFFFFFE71, wch_pkg::RESP_OKAY);
    rd(8'h80, 32'h0, wch_pkg::RESP_SLVERR);
    wr(8'h84, 5, wch_pkg::RESP_SLVERR);
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    stop_test;
  end
endmodule // wch_top_tb_top
bind wch_top wch_props u_wch_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cmp_out);
`default_nettype wire
